// [core/ecc_dbg_cfg.svh]
// constants of the ecc debug access block: offsets, fields, resets
// assumes inclusion by bare name from the package and the top module
`ifndef ECC_DBG_CFG_SVH
`define ECC_DBG_CFG_SVH

// wishbone byte offsets of the four registers
`define OFS_CTRL    4'h0
`define OFS_PTR     4'h4
`define OFS_DATA    4'h8
`define OFS_CHECK   4'hC

// control register bit positions
`define CTRL_WR_BIT  0
`define CTRL_RD_BIT  1
`define CTRL_RRD_BIT 2
`define CTRL_RDY_BIT 3

// widths of the stored word, of the pointer and of the memory word address
`define DATA_W  16
`define CHK_W   6
`define PTR_W   16
`define MEM_AW  10

// reset values
`define DATA_RST  16'h0000
`define CHK_RST   6'h00
`define PTR_RST   16'h0000

// check bit masks over the 16 bit data word
`define ECC_M0 16'h443F
`define ECC_M1 16'h13C7
`define ECC_M2 16'hE1D1
`define ECC_M3 16'hEE60
`define ECC_M4 16'h3E8A
`define ECC_M5 16'h993C

`endif

// [core/ecc_dbg_pkg.sv]
// types shared by the ecc debug access block
// assumes the cfg header sits next to it on the include path
`include "ecc_dbg_cfg.svh"

package ecc_dbg_pkg;

    // engine states
    typedef enum logic [1:0]
    {
        ST_INIT = 2'b00,  // zero fill after reset
        ST_IDLE = 2'b01,  // ordinary and debug issue
        ST_RD   = 2'b10   // debug read data returning
    } state_t;

    // one stored memory word
    typedef struct packed
    {
        logic [`CHK_W-1:0]  check;  // raw check bits
        logic [`DATA_W-1:0] data;   // raw data word
    } mem_word_t;

    // all state of the top module
    typedef struct packed
    {
        state_t             state;    // engine state
        logic               wr_req;   // debug write request
        logic               rd_req;   // debug read request
        logic               rrd;      // read repair disable
        logic [`PTR_W-1:0]  ptr;      // debug address pointer
        logic [`DATA_W-1:0] data;     // debug data word
        logic [`CHK_W-1:0]  check;    // debug check bits
        logic [`PTR_W-1:0]  init_cnt; // zero fill index
        logic               wb_ack;   // bus answer
        logic [31:0]        wb_dat;   // bus read data
        logic               sys_ack;  // ordinary access done
        logic               sys_rd;   // ordinary read returns
        logic               err;      // single error flag pulse
    } dbg_state_t;

endpackage : ecc_dbg_pkg

// [core/ecc_dbg_mem.sv]
// single port word memory with registered read data
// assumes one access per cycle, caller holds en for a single cycle
module ecc_dbg_mem
#(
    parameter int AW = 10,  // address width in words
    parameter int W  = 22   // word width
)
(
    input  wire logic          ref_clk, // system clock
    input  wire logic          rst_n,   // async reset, low
    input  wire logic          en,      // access enable
    input  wire logic          we,      // write when high
    input  wire logic [AW-1:0] addr,    // word address
    input  wire logic [W-1:0]  wdata,   // write word
    output logic      [W-1:0]  rdata    // read word, registered
);

    // refuse shapes the array cannot take, at elaboration
    if (AW < 1 || AW > 15 || W < 1)
    begin : g_bad_shape
        $error("ecc_dbg_mem: bad AW or W");
    end

    logic [W-1:0] mem [0:(1<<AW)-1];  // storage array

    // array write, no reset on storage
    always_ff @(posedge ref_clk)
    begin
        if (en && we)
            mem[addr] <= wdata;
    end

    // read port register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata <= '0;
        else if (en && !we)
            rdata <= mem[addr];
    end

endmodule : ecc_dbg_mem

// [core/sram_ecc_debug_access.sv]
// ecc debug access engine with its wishbone register file
// assumes a classic wishbone master and an ordinary single-cycle
// memory client on the same 20 MHz ref_clk
`include "ecc_dbg_cfg.svh"

// Function
// - debug write goes to pointer address
// - write stores data and check bits raw
// - write request bit clears after write
// - debug write is one aligned word
// - debug write raises no error flag
// - debug read reads at pointer address
// - data register holds uncorrected read word
// - check register holds raw read check bits
// - debug read never writes back memory
// - debug read raises no error flag
// - both bits set: only the write
// - ordinary accesses served before debug ones
// - debug waits until zero fill finishes
// - request writes ignored while access active
module sram_ecc_debug_access
    import ecc_dbg_pkg::*;
#(
    parameter int AW = `MEM_AW  // memory address width in words
)
(
    input  wire logic              ref_clk,   // system clock
    input  wire logic              rst_n,     // async reset, low
    input  wire logic              wb_cyc_i,  // bus cycle
    input  wire logic              wb_stb_i,  // bus strobe
    input  wire logic              wb_we_i,   // bus write
    input  wire logic [3:0]        wb_adr_i,  // byte address
    input  wire logic [3:0]        wb_sel_i,  // byte lanes
    input  wire logic [31:0]       wb_dat_i,  // write data
    output logic      [31:0]       wb_dat_o,  // read data
    output logic                   wb_ack_o,  // answer
    input  wire logic              sys_req,   // ordinary access
    input  wire logic              sys_we,    // ordinary write
    input  wire logic [AW-1:0]     sys_addr,  // ordinary word addr
    input  wire logic [15:0]       sys_wdata, // ordinary write data
    output logic                   sys_ready, // memory accessible
    output logic                   sys_ack,   // access done
    output logic      [15:0]       sys_rdata, // ordinary read data
    output logic                   single_error_flag // check error
);

    import ecc_dbg_pkg::*;

    // refuse widths the pointer cannot address, at elaboration
    if (AW < 1 || AW >= `PTR_W)
    begin : g_bad_aw
        $error("sram_ecc_debug_access: bad AW");
    end

    // check bits of a data word
    function automatic logic [`CHK_W-1:0] ecc_of
    (
        input logic [`DATA_W-1:0] d
    );
        ecc_of[0] = ~(^(d & `ECC_M0));
        ecc_of[1] = ~(^(d & `ECC_M1));
        ecc_of[2] = ~(^(d & `ECC_M2));
        ecc_of[3] = ~(^(d & `ECC_M3));
        ecc_of[4] = ~(^(d & `ECC_M4));
        ecc_of[5] = ~(^(d & `ECC_M5));
    endfunction : ecc_of

    // merge the two low byte lanes of a write into a 16 bit value
    function automatic logic [15:0] lane_merge
    (
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0]  sel
    );
        lane_merge = old;
        if (sel[0])
            lane_merge[7:0] = wd[7:0];
        if (sel[1])
            lane_merge[15:8] = wd[15:8];
    endfunction : lane_merge

    dbg_state_t q;       // registered state
    dbg_state_t next_q;  // next state

    logic            m_en;    // memory enable
    logic            m_we;    // memory write
    logic [AW-1:0]   m_addr;  // memory word address
    mem_word_t       m_wd;    // memory write word
    mem_word_t       m_rd;    // memory read word
    logic [`PTR_W-1:0] last_idx; // final zero fill index

    logic            bus_hit;  // request on the bus
    logic            bus_wr;   // write takes effect now
    logic            sys_go;   // ordinary access issued
    logic            dbg_go;   // debug access issued
    logic            busy;     // a debug access is active

    assign last_idx = `PTR_W'((1 << AW) - 1);
    assign bus_hit  = wb_cyc_i && wb_stb_i;
    assign bus_wr   = bus_hit && q.wb_ack && wb_we_i;
    assign busy     = q.wr_req || q.rd_req;
    assign sys_go   = sys_req && (q.state != ST_INIT);
    assign dbg_go   = !sys_go && (q.state == ST_IDLE) && busy;

    // outputs straight from flops, sys_ready decoded from the state
    assign wb_ack_o          = q.wb_ack;
    assign wb_dat_o          = q.wb_dat;
    assign sys_ack           = q.sys_ack;
    assign sys_rdata         = m_rd.data;
    assign single_error_flag = q.err;
    assign sys_ready         = (q.state != ST_INIT);

    // word memory, raw data and check bits side by side
    ecc_dbg_mem
    #(
        .AW (AW),
        .W  (`DATA_W + `CHK_W)
    )
    u_mem
    (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .en      (m_en),
        .we      (m_we),
        .addr    (m_addr),
        .wdata   (m_wd),
        .rdata   (m_rd)
    );

    // next state: bus slave, then ordinary access on the port, then engine
    always_comb
    begin
        next_q         = q;
        next_q.wb_ack  = 1'b0;
        next_q.sys_ack = 1'b0;
        next_q.sys_rd  = 1'b0;
        m_en           = 1'b0;
        m_we           = 1'b0;
        m_addr         = '0;
        m_wd           = '0;
        // flag follows only ordinary reads
        next_q.err = q.sys_rd && (ecc_of(m_rd.data) != m_rd.check);

        // bus answer one cycle after the request
        if (bus_hit && !q.wb_ack)
        begin
            next_q.wb_ack = 1'b1;
            if (wb_adr_i == `OFS_CTRL)
            begin
                next_q.wb_dat = '0;
                next_q.wb_dat[`CTRL_WR_BIT]  = q.wr_req;
                next_q.wb_dat[`CTRL_RD_BIT]  = q.rd_req;
                next_q.wb_dat[`CTRL_RRD_BIT] = q.rrd;
                next_q.wb_dat[`CTRL_RDY_BIT] = (q.state != ST_INIT);
            end
            else if (wb_adr_i == `OFS_PTR)
                next_q.wb_dat = {16'h0000, q.ptr};
            else if (wb_adr_i == `OFS_DATA)
                next_q.wb_dat = {16'h0000, q.data};
            else if (wb_adr_i == `OFS_CHECK)
                next_q.wb_dat = {26'h0000000, q.check};
            else
                next_q.wb_dat = '0;  // unmapped reads zero
        end

        // register writes at the acknowledging edge
        if (bus_wr)
        begin
            if (wb_adr_i == `OFS_CTRL)
            begin
                if (wb_sel_i[0])
                begin
                    next_q.rrd = wb_dat_i[`CTRL_RRD_BIT];
                    // new requests only when nothing runs
                    if (!busy)
                    begin
                        next_q.wr_req = wb_dat_i[`CTRL_WR_BIT];
                        next_q.rd_req = wb_dat_i[`CTRL_RD_BIT];
                    end
                end
            end
            else if (wb_adr_i == `OFS_PTR)
            begin
                next_q.ptr = lane_merge(q.ptr, wb_dat_i, wb_sel_i);
                next_q.ptr[0] = 1'b0;
            end
            else if (wb_adr_i == `OFS_DATA)
                next_q.data = lane_merge(q.data, wb_dat_i, wb_sel_i);
            else if (wb_adr_i == `OFS_CHECK)
            begin
                if (wb_sel_i[0])
                    next_q.check = wb_dat_i[`CHK_W-1:0];
            end
        end

        // ordinary access takes the port first
        if (sys_go)
        begin
            m_en          = 1'b1;
            m_we          = sys_we;
            m_addr        = sys_addr;
            m_wd.data     = sys_wdata;
            m_wd.check    = ecc_of(sys_wdata);
            next_q.sys_ack = 1'b1;
            next_q.sys_rd  = !sys_we;
        end

        case (q.state)
            ST_INIT:
            begin
                // zero fill with valid check bits, debug waits
                m_en       = 1'b1;
                m_we       = 1'b1;
                m_addr     = q.init_cnt[AW-1:0];
                m_wd.data  = `DATA_RST;
                m_wd.check = ecc_of(`DATA_RST);
                if (q.init_cnt == last_idx)
                    next_q.state = ST_IDLE;
                else
                    next_q.init_cnt = q.init_cnt + `PTR_W'(1);
            end
            ST_IDLE:
            begin
                if (dbg_go && q.wr_req)
                begin
                    // raw aligned word write, no check made
                    m_en          = 1'b1;
                    m_we          = 1'b1;
                    m_addr        = q.ptr[AW:1];
                    m_wd.data     = q.data;
                    m_wd.check    = q.check;
                    next_q.wr_req = 1'b0;
                    next_q.rd_req = 1'b0;
                end
                else if (dbg_go)
                begin
                    // raw read, never written back
                    m_en         = 1'b1;
                    m_we         = 1'b0;
                    m_addr       = q.ptr[AW:1];
                    next_q.state = ST_RD;
                end
            end
            ST_RD:
            begin
                // capture word as stored, then release
                next_q.data   = m_rd.data;
                next_q.check  = m_rd.check;
                next_q.rd_req = 1'b0;
                next_q.state  = ST_IDLE;
            end
            default:
                next_q.state = ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q          <= '0;
            q.state    <= ST_INIT;
            q.ptr      <= `PTR_RST;
            q.data     <= `DATA_RST;
            q.check    <= `CHK_RST;
        end
        else
            q <= next_q;
    end

    // checks on the engine
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // write lands at pointer word with raw contents
    a_wr_raw_word: assert property (
        (dbg_go && q.wr_req) |-> m_en && m_we
        && m_addr == q.ptr[AW:1] && m_wd == {q.check, q.data})
        else $error("debug write word wrong");

    // write request drops right after the write
    a_wr_req_clear: assert property (
        (dbg_go && q.wr_req) |=> !q.wr_req && !q.rd_req
        && q.state == ST_IDLE)
        else $error("write request not cleared");

    // read request and data settle two cycles on
    a_rd_loads_word: assert property (
        (dbg_go && !q.wr_req) |=> q.state == ST_RD && q.rd_req
        ##1 !q.rd_req && q.data == $past(m_rd.data)
        && q.check == $past(m_rd.check))
        else $error("debug read result wrong");

    // issue of a debug read writes nothing
    a_rd_no_repair: assert property (
        (dbg_go && !q.wr_req) |-> !m_we && m_addr == q.ptr[AW:1])
        else $error("debug read wrote memory");

    // flag only after an ordinary read
    a_err_source: assert property (
        q.err |-> $past(q.sys_rd))
        else $error("error flag without ordinary read");

    // ordinary request owns the port
    a_sys_priority: assert property (
        sys_go |-> m_en && m_addr == sys_addr && !dbg_go
        ##1 sys_ack)
        else $error("ordinary access not served first");

    // pending write waits out the zero fill
    a_init_defers: assert property (
        (q.state == ST_INIT && q.wr_req) |=> q.wr_req)
        else $error("debug access during zero fill");

    // no new write request while a read runs
    a_busy_ignore: assert property (
        (q.rd_req && !q.wr_req) |=> !q.wr_req)
        else $error("request accepted while busy");

    // pointer stays word aligned
    a_ptr_aligned: assert property (
        !q.ptr[0])
        else $error("pointer not aligned");

    // data register moves only by bus write or read
    a_data_stable: assert property (
        (!bus_wr && q.state != ST_RD) |=> $stable(q.data))
        else $error("data register changed unexpectedly");

    // debug accesses never lead to the error flag
    a_dbg_no_flag: assert property (
        dbg_go |-> ##2 !q.err)
        else $error("error flag after debug access");

    // both bits: the write is issued and no read follows
    a_both_write_only: assert property (
        (dbg_go && q.wr_req && q.rd_req) |-> m_we
        ##1 q.state == ST_IDLE && !q.rd_req)
        else $error("read done beside debug write");

    // while read data return, any port write is an ordinary one
    a_rd_no_writeback: assert property (
        (q.state == ST_RD && m_we) |-> sys_go)
        else $error("debug read wrote back");

endmodule : sram_ecc_debug_access

// [testbench/sram_ecc_debug_access_tb_top.sv]
// bench of the ecc debug access block: word model, bus tasks, scenarios
// assumes the core files compiled first and the cfg header on the path
`include "ecc_dbg_cfg.svh"
`define CHK(g, e) chk(32'(g), 32'(e))

module sram_ecc_debug_access_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ecc_dbg_pkg::*;

    localparam int AW = 4;           // short zero fill of 16 cycles

    logic        ref_clk;            // 20 MHz clock
    logic        rst_n;              // reset, low
    logic        cyc;                // bus cycle
    logic        stb;                // bus strobe
    logic        we;                 // bus write
    logic [3:0]  adr;                // bus byte address
    logic [31:0] dat;                // bus write data
    logic [3:0]  sel;                // bus byte lanes
    logic [3:0]  lanes;              // lanes for the next bus cycle
    logic [31:0] wb_dat_o;           // bus read data
    logic        wb_ack_o;           // bus answer
    logic        sys_req;            // ordinary access strobe
    logic        sys_we;             // ordinary write
    logic [3:0]  sys_addr;           // ordinary word address
    logic [15:0] sys_wdata;          // ordinary write data
    logic        sys_ready;          // fill done
    logic        sys_ack;            // ordinary done
    logic [15:0] sys_rdata;          // ordinary read data
    logic        single_error_flag;  // check mismatch pulse
    logic [15:0] m_d [16];           // model data words
    logic [5:0]  m_c [16];           // model check bits
    logic [31:0] q;                  // last bus read
    logic [15:0] d;                  // scratch data
    int          error_cnt;          // mismatches
    int          num_checks;         // comparisons
    int          flag_cnt;           // flag pulses seen
    int          exp_flags;          // flag pulses expected

    // design under test, lanes driven by the bus task
    sram_ecc_debug_access #(.AW(AW)) dut
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sys_req(sys_req),
        .sys_we(sys_we), .sys_addr(sys_addr), .sys_wdata(sys_wdata),
        .sys_ready(sys_ready), .sys_ack(sys_ack), .sys_rdata(sys_rdata),
        .single_error_flag(single_error_flag)
    );

    // clock generator
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // count error flag pulses
    always @(posedge ref_clk)
        if (single_error_flag === 1'b1) flag_cnt++;

    // watchdog against a hung handshake
    initial
    begin
        #(50 * 20000);
        error_cnt++;
        test_done();
    end

    // reference check bits of a data word
    function automatic logic [5:0] ecc(input logic [15:0] x);
        return {~^(x & `ECC_M5), ~^(x & `ECC_M4), ~^(x & `ECC_M3),
                ~^(x & `ECC_M2), ~^(x & `ECC_M1), ~^(x & `ECC_M0)};
    endfunction : ecc

    // four-state compare with report
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    // one classic wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] v);
        int n;
        @(posedge ref_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= lanes;
        dat <= v;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 40);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 40) error_cnt++;
    endtask : wb

    // poll control until the masked bits match
    task automatic poll(input logic [31:0] m, input logic [31:0] v);
        int n;
        n = 0;
        do
        begin
            wb(1'b0, `OFS_CTRL, 32'h0);
            n++;
        end
        while ((q & m) !== v && n < 60);
        if (n >= 60) error_cnt++;
    endtask : poll

    // debug write of a raw word, odd pointer bit set on purpose
    task automatic dbg_wr(input int a, input logic [15:0] v,
                          input logic [5:0] c);
        wb(1'b1, `OFS_PTR, 32'((a << 1) | 1));
        wb(1'b0, `OFS_PTR, 32'h0);
        `CHK(q, a << 1);
        wb(1'b1, `OFS_DATA, 32'(v));
        wb(1'b1, `OFS_CHECK, 32'(c));
        wb(1'b1, `OFS_CTRL, 32'h1);
        poll(32'h3, 32'h0);
        m_d[a] = v;
        m_c[a] = c;
    endtask : dbg_wr

    // debug read, repair disable given, result against the model
    task automatic dbg_rd(input int a, input logic rrd);
        wb(1'b1, `OFS_PTR, 32'(a << 1));
        wb(1'b1, `OFS_CTRL, {29'h0, rrd, 2'b10});
        poll(32'h3, 32'h0);
        wb(1'b0, `OFS_DATA, 32'h0);
        `CHK(q, m_d[a]);
        wb(1'b0, `OFS_CHECK, 32'h0);
        `CHK(q, m_c[a]);
    endtask : dbg_rd

    // ordinary single access, flag expected on a check mismatch
    task automatic sys_acc(input logic w, input int a, input logic [15:0] v);
        @(posedge ref_clk);
        sys_req   <= 1'b1;
        sys_we    <= w;
        sys_addr  <= 4'(a);
        sys_wdata <= v;
        @(posedge ref_clk);
        sys_req <= 1'b0;
        @(posedge ref_clk);
        `CHK(sys_ack, 1'b1);
        if (w)
        begin
            m_d[a] = v;
            m_c[a] = ecc(v);
        end
        else
        begin
            `CHK(sys_rdata, m_d[a]);
            if (m_c[a] !== ecc(m_d[a])) exp_flags++;
        end
        repeat (2) @(posedge ref_clk);
    endtask : sys_acc

    // verdict and end of run
    task automatic test_done();
        $display("errors %0d checks %0d", error_cnt, num_checks);
        if (error_cnt == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // main sequence
    initial
    begin
        {cyc, stb, we, adr, dat} = '0;
        sel = 4'h0;
        lanes = 4'hF;
        {sys_req, sys_we, sys_addr, sys_wdata} = '0;
        {error_cnt, num_checks, flag_cnt, exp_flags} = '0;
        rst_n = 1'b0;
        void'($urandom(32'h73024580));
        for (int i = 0; i < 16; i++)
        begin
            m_d[i] = 16'h0000;
            m_c[i] = ecc(16'h0000);
        end
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        // request during fill: reset registers land raw at the last word
        wb(1'b1, `OFS_PTR, 32'h1E);
        wb(1'b1, `OFS_CTRL, 32'h1);
        poll(32'h8, 32'h8);
        poll(32'h3, 32'h0);
        m_c[15] = 6'h00;
        sys_acc(1'b0, 15, 16'h0);
        wb(1'b0, `OFS_DATA, 32'h0);
        `CHK(q, 32'h0);
        wb(1'b0, `OFS_CHECK, 32'h0);
        `CHK(q, 32'h0);
        wb(1'b0, 4'h2, 32'h0);
        `CHK(q, 32'h0);
        // raw writes with good and bad check bits
        for (int i = 1; i < 7; i++)
        begin
            d = 16'($urandom);
            dbg_wr(i, d, ($urandom % 2) ? ecc(d) : 6'($urandom));
            sys_acc(1'b0, i, 16'h0);
        end
        `CHK(flag_cnt, exp_flags);
        // raw reads, no repair whatever the disable bit says
        for (int i = 1; i < 7; i++)
        begin
            dbg_rd(i, 1'(i));
            sys_acc(1'b0, i, 16'h0);
        end
        `CHK(flag_cnt, exp_flags);
        // both request bits: write only
        d = 16'($urandom);
        wb(1'b1, `OFS_PTR, 32'h4);
        wb(1'b1, `OFS_DATA, 32'(d));
        wb(1'b1, `OFS_CHECK, 32'(ecc(d)));
        wb(1'b1, `OFS_CTRL, 32'h3);
        poll(32'h3, 32'h0);
        `CHK(q[1:0], 2'b00);
        m_d[2] = d;
        m_c[2] = ecc(d);
        sys_acc(1'b0, 2, 16'h0);
        // upper lane only: low pointer byte kept
        lanes = 4'h2;
        wb(1'b1, `OFS_PTR, 32'h0300);
        lanes = 4'hF;
        wb(1'b0, `OFS_PTR, 32'h0);
        `CHK(q, 32'h0304);
        // ordinary traffic holds off a read; a second request is dropped
        wb(1'b1, `OFS_PTR, 32'h8);
        wb(1'b1, `OFS_DATA, 32'(~m_d[4]));
        @(posedge ref_clk);
        sys_req  <= 1'b1;
        sys_we   <= 1'b0;
        sys_addr <= 4'h0;
        wb(1'b1, `OFS_CTRL, 32'h2);
        wb(1'b0, `OFS_CTRL, 32'h0);
        `CHK(q[1:0], 2'b10);
        wb(1'b1, `OFS_CTRL, 32'h1);
        wb(1'b0, `OFS_CTRL, 32'h0);
        `CHK(q[1:0], 2'b10);
        @(posedge ref_clk);
        sys_req <= 1'b0;
        poll(32'h3, 32'h0);
        wb(1'b0, `OFS_DATA, 32'h0);
        `CHK(q, m_d[4]);
        sys_acc(1'b0, 4, 16'h0);
        // ordinary write read back raw through the debug path
        sys_acc(1'b1, 5, 16'($urandom));
        dbg_rd(5, 1'b0);
        `CHK(flag_cnt, exp_flags);
        test_done();
    end

endmodule : sram_ecc_debug_access_tb_top
